// file: src/fcms_pkg.sv
// constants and types for the fail-safe clock monitor and oscillator control
// ****************************************
// ****************************************
package fcms_pkg;

  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAIL_STAT = 8'h04;

  localparam int CTRL_PLL_BIT = 7;
  localparam int CTRL_IRCF_LSB = 3;
  localparam int CTRL_SCS_LSB = 0;
  localparam logic       PLL_RST = 1'b0;
  localparam logic [3:0] IRCF_RST = 4'h7;
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [1:0] SCS_CFG = 2'h0;
  localparam logic [1:0] SCS_T1 = 2'h1;
  localparam logic [2:0] IRCF_LF_TOP = 3'h0;
  localparam logic [3:0] IRCF_1M = 4'hb;
  localparam logic [3:0] IRCF_8M = 4'he;

  localparam int STAT_FLAG = 0;
  localparam int STAT_IE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_OSTS = 3;
  localparam int STAT_EXT = 4;

  localparam int LF_DIV = 64;
  localparam int OST_CYCLES = 1024;

  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_INT = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SRC_OFF, SRC_EXT, SRC_INT, SRC_T1} fcms_src_t;

  typedef struct packed {
    logic       two_speed;
    logic       monitor_en;
    logic       pll_en;
    logic [2:0] osc_mode;
  } fcms_cfg_t;

  typedef struct packed {
    logic t1osc;
    logic internal_osc_block;
    logic lfint;
    logic ext;
  } fcms_pins_t;

endpackage

// file: src/fcms_top.sv
// fail-safe clock monitor, glitch-free clock select and register slave
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fcms_top
  import fcms_pkg::*;
#(
  parameter int AW      = 8,
  parameter int DIV     = LF_DIV,
  parameter int OST_LEN = OST_CYCLES
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output var  logic          awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output var  logic          wready,
  output var  logic [1:0]    bresp,
  output var  logic          bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output var  logic          arready,
  output var  logic [31:0]   rdata,
  output var  logic [1:0]    rresp,
  output var  logic          rvalid,
  input  wire logic          rready,
  input  wire fcms_pins_t    pins,
  input  wire fcms_cfg_t     cfg,
  input  wire logic          sleep_enter,
  input  wire logic          wake_event,
  output var  logic          sys_clk,
  output var  fcms_src_t     sys_src,
  output var  logic [3:0]    int_freq_select,
  output var  logic          pll_on,
  output var  logic          hf_pll_boost,
  output var  logic          osc_fail_flag,
  output var  logic          osc_fail_irq,
  output var  logic          failsafe_active,
  output var  logic          startup_done
);

  localparam int HALF = DIV / 2;
  localparam int DW = $clog2(HALF);
  localparam int OW = $clog2(OST_LEN);
  localparam logic [DW-1:0] DIV_LAST = DW'(HALF - 1);
  localparam logic [OW-1:0] OST_LAST = OW'(OST_LEN - 1);

  generate
    if (AW < 8 || DIV < 4 || DIV % 2 != 0 || OST_LEN < 2) begin : g_chk
      $error("fcms_top: unsupported parameter value");
    end
  endgenerate

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev  <= 4'h0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  logic ext_fall;
  logic lf_rise;
  assign ext_fall = prev[0] & ~sync2[0];
  assign lf_rise = ~prev[1] & sync2[1];

  // ****************************************
  // register slave
  // ****************************************
  logic       soft_pll;
  logic [3:0] ircf;
  logic [1:0] scs;
  logic       scs_chg;
  logic       irq_en;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       aw_hit;
  logic       ar_hit;
  fcms_src_t  cur_src;
  logic       fail_active;
  logic       ost_done;

  assign aw_hit = (awaddr[7:0] == ADDR_OSC_CTRL) || (awaddr[7:0] == ADDR_FAIL_STAT);
  assign ar_hit = (araddr[7:0] == ADDR_OSC_CTRL) || (araddr[7:0] == ADDR_FAIL_STAT);
  assign wr_ctrl = awready && (awaddr[7:0] == ADDR_OSC_CTRL) && wstrb[0];
  assign wr_stat = awready && (awaddr[7:0] == ADDR_FAIL_STAT) && wstrb[0];

  // address and data are taken together, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= 1'b0;
      wready  <= 1'b0;
      if (awvalid && wvalid && !awready && !bvalid) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (awready) begin
        bvalid <= 1'b1;
        bresp  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= 1'b0;
      if (arvalid && !arready && !rvalid) begin
        arready <= 1'b1;
      end
      if (arready) begin
        rvalid <= 1'b1;
        rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        if (araddr[7:0] == ADDR_OSC_CTRL) begin
          rdata <= {24'h0, soft_pll, ircf, 1'b0, scs};
        end else if (araddr[7:0] == ADDR_FAIL_STAT) begin
          rdata <= {27'h0, cur_src == SRC_EXT, ost_done, fail_active,
                    irq_en, osc_fail_flag};
        end else begin
          rdata <= 32'h0;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_pll <= PLL_RST;
      ircf     <= IRCF_RST;
      scs      <= SCS_RST;
      scs_chg  <= 1'b0;
    end else begin
      scs_chg <= 1'b0;
      if (wr_ctrl) begin
        soft_pll <= wdata[CTRL_PLL_BIT];
        ircf     <= wdata[CTRL_IRCF_LSB +: 4];
        scs      <= wdata[CTRL_SCS_LSB +: 2];
        scs_chg  <= wdata[CTRL_SCS_LSB +: 2] != scs;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= 1'b0;
    end else if (wr_stat) begin
      irq_en <= wdata[STAT_IE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_on          <= 1'b0;
      hf_pll_boost    <= 1'b0;
      int_freq_select <= IRCF_RST;
    end else begin
      pll_on          <= cfg.pll_en | soft_pll;
      hf_pll_boost    <= (cfg.pll_en | soft_pll) && (ircf == IRCF_8M);
      int_freq_select <= ircf;
    end
  end

  // ****************************************
  // sleep and start-up timer
  // ****************************************
  logic          asleep;
  logic [OW-1:0] ost_cnt;
  logic          ost_skip;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asleep <= 1'b0;
    end else if (sleep_enter) begin
      asleep <= 1'b1;
    end else if (wake_event) begin
      asleep <= 1'b0;
    end
  end

  // no timer for internal oscillator or rc modes
  assign ost_skip = !(cfg.osc_mode == MODE_LP || cfg.osc_mode == MODE_XT ||
                      cfg.osc_mode == MODE_HS);

  always_ff @(posedge aclk) begin
    if (!aresetn || sleep_enter || wake_event || scs_chg) begin
      ost_cnt  <= '0;
      ost_done <= 1'b0;
    end else if (!ost_done && !asleep) begin
      if (ost_skip) begin
        ost_done <= 1'b1;
      end else if (ext_fall) begin
        if (ost_cnt == OST_LAST) begin
          ost_done <= 1'b1;
        end else begin
          ost_cnt <= ost_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // sample clock and fail detector
  // ****************************************
  logic [DW-1:0] div_cnt;
  logic          samp;
  logic          samp_rise;
  logic          samp_fall;
  logic          fail_latch;
  logic          mon_active;
  logic          fail_det;

  assign samp_rise = lf_rise && (div_cnt == DIV_LAST) && !samp;
  assign samp_fall = lf_rise && (div_cnt == DIV_LAST) && samp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
      samp    <= 1'b0;
    end else if (lf_rise) begin
      if (div_cnt == DIV_LAST) begin
        div_cnt <= '0;
        samp    <= ~samp;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_latch <= 1'b0;
    end else if (ext_fall) begin
      fail_latch <= 1'b1;
    end else if (samp_rise) begin
      fail_latch <= 1'b0;
    end
  end

  // watch only a settled external clock
  assign mon_active = cfg.monitor_en && ost_done && !asleep &&
                      (cur_src == SRC_EXT) && !fail_active;
  // high half elapsed with no falling edge
  assign fail_det = mon_active && samp_fall && !fail_latch && !ext_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_active <= 1'b0;
    end else if (fail_det) begin
      fail_active <= 1'b1;
    end else if (sleep_enter || scs_chg) begin
      fail_active <= 1'b0;
    end
  end

  // flag clear only after fail-safe ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_fail_flag <= 1'b0;
    end else if (fail_det) begin
      osc_fail_flag <= 1'b1;
    end else if (wr_stat && wdata[STAT_FLAG] && !fail_active) begin
      osc_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_fail_irq <= 1'b0;
    end else begin
      osc_fail_irq <= osc_fail_flag && irq_en;
    end
  end

  // ****************************************
  // source choice and glitch-free switch
  // ****************************************
  fcms_src_t target;
  logic      parked;

  always_comb begin
    target = SRC_OFF;
    if (asleep) begin
      target = SRC_OFF;
    end else if (fail_active || scs[1]) begin
      target = SRC_INT;
    end else if (scs == SCS_T1) begin
      target = SRC_T1;
    end else if (cfg.osc_mode == MODE_INT) begin
      target = SRC_INT;
    end else if (ost_done) begin
      target = SRC_EXT;
    end else if (cfg.two_speed || cfg.monitor_en) begin
      target = SRC_INT;
    end
  end

  function automatic logic src_level(input fcms_src_t s, input logic [3:0] lv);
    case (s)
      SRC_EXT: src_level = lv[0];
      SRC_INT: src_level = lv[2];
      SRC_T1:  src_level = lv[3];
      default: src_level = 1'b0;
    endcase
  endfunction

  // park low, then take new source while it is low
  // a dead external clock may sit high, so fail-over parks without waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_src <= SRC_OFF;
      parked  <= 1'b0;
    end else if (!parked && target != cur_src &&
                 (!src_level(cur_src, sync2) || (fail_active && cur_src == SRC_EXT))) begin
      parked <= 1'b1;
    end else if (parked && !src_level(target, sync2)) begin
      cur_src <= target;
      parked  <= 1'b0;
    end
  end

  // output clock is resampled, so it is only as fine as aclk allows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk         <= 1'b0;
      sys_src         <= SRC_OFF;
      failsafe_active <= 1'b0;
      startup_done    <= 1'b0;
    end else begin
      sys_clk         <= parked ? 1'b0 : src_level(cur_src, sync2);
      sys_src         <= cur_src;
      failsafe_active <= fail_active;
      startup_done    <= ost_done;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  div_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lf_rise && div_cnt == DIV_LAST |=> samp != $past(samp))
    else $error("sample clock did not toggle");
  latch_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_fall |=> fail_latch)
    else $error("fail latch not set");
  latch_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    samp_rise && !ext_fall |=> !fail_latch)
    else $error("fail latch not cleared");
  fail_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fail_active) |-> $past(samp_fall && !fail_latch && cur_src == SRC_EXT))
    else $error("failure without empty half period");
  fail_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fail_det |=> osc_fail_flag && target == SRC_INT)
    else $error("failure not flagged");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_fail_flag && irq_en |=> osc_fail_irq)
    else $error("interrupt missing");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fail_active && osc_fail_flag |=> osc_fail_flag)
    else $error("flag cleared during fail-safe");
  ost_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ost_done) && !ost_skip |-> $past(ost_cnt == OST_LAST && ext_fall))
    else $error("start-up timer too short");
  switch_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cur_src != $past(cur_src) |-> !sys_clk && $past(parked))
    else $error("switch while clock high");

endmodule
`default_nettype wire

// file: tb/fcms_osc_model.sv
// oscillator pin model: stoppable external clock, free-running internal clocks
`timescale 1ns/1ps
`default_nettype none
module fcms_osc_model
  import fcms_pkg::*;
#(
  parameter int EXT_HALF = 50,
  parameter int LF_HALF  = 60
) (
  input  wire logic       ext_run,
  output var  fcms_pins_t pins
);
  logic ext;
  logic lf;
  logic io;
  logic t1;
  initial begin
    ext = 1'b0;
    lf = 1'b0;
    io = 1'b0;
    t1 = 1'b0;
  end
  always #LF_HALF lf = ~lf;
  always #27 io = ~io;
  always #70 t1 = ~t1;
  // a dead crystal is parked high, so no falling edge reaches the monitor
  always #EXT_HALF ext = ext_run ? ~ext : 1'b1;
  assign pins = '{t1osc: t1, internal_osc_block: io, lfint: lf, ext: ext};
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the fail-safe clock monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fcms_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sleep_enter, wake_event, run;
  logic sys_clk, pll_on, hf_pll_boost, osc_fail_flag, osc_fail_irq;
  logic failsafe_active, startup_done;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, int_freq_select;
  logic [1:0] bresp, rresp, r;
  fcms_src_t sys_src;
  fcms_pins_t pins;
  fcms_cfg_t cfg;
  int n_mismatch, total_checks, n0, n1;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hb, 4'he};

  // short divider and start-up count keep the run brief
  fcms_top #(.AW(8), .DIV(4), .OST_LEN(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pins), .cfg(cfg),
    .sleep_enter(sleep_enter), .wake_event(wake_event), .sys_clk(sys_clk),
    .sys_src(sys_src), .int_freq_select(int_freq_select), .pll_on(pll_on),
    .hf_pll_boost(hf_pll_boost), .osc_fail_flag(osc_fail_flag),
    .osc_fail_irq(osc_fail_irq), .failsafe_active(failsafe_active),
    .startup_done(startup_done));
  fcms_osc_model osc (.ext_run(run), .pins(pins));

  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // both valids offered together, each dropped once taken; bready stays high between writes
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd && bvalid) && n < 100);
    rs = bresp;
    if (n >= 100) chk(32'h0, 32'h1);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ad;
    n = 0;
    ad = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!(ad && rvalid) && n < 100);
    v = rdata;
    rs = rresp;
    if (n >= 100) chk(32'h0, 32'h1);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return osc_fail_flag === 1'b1;
      1: return startup_done === 1'b1;
      2: return sys_src === SRC_INT;
      default: return sys_src === SRC_EXT;
    endcase
  endfunction

  // bounded wait; running out counts as a mismatch
  task automatic wfor(input int sel, input int lim, output int n);
    n = 0;
    while (!pick(sel) && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n < lim), 32'h1);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic pulse_sleep(input logic wake);
    @(posedge aclk);
    if (wake) wake_event <= 1'b1;
    else sleep_enter <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    sleep_enter <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    #200us;
    n_mismatch++;
    results();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sleep_enter, wake_event, awaddr, araddr, wdata, wstrb} = '0;
    n_mismatch = 0;
    total_checks = 0;
    run = 1'b1;
    cfg = '{two_speed: 1'b0, monitor_en: 1'b1, pll_en: 1'b0, osc_mode: MODE_XT};
    rst();
    wfor(2, 25, n0);
    wfor(1, 400, n1);
    chk(32'(n0 + n1 >= 30), 32'h1);
    wfor(3, 60, n0);
    n1 = 0;
    repeat (20) begin
      @(posedge aclk);
      n1 += int'(sys_clk);
    end
    chk(32'(n1 > 0 && n1 < 20), 32'h1);
    axr(ADDR_OSC_CTRL, d, r);
    chk(d, 32'h38);
    foreach (codes[i]) begin
      axw(ADDR_OSC_CTRL, {25'h0, codes[i], 3'h0}, r);
      axr(ADDR_OSC_CTRL, d, r);
      chk(d, {25'h0, codes[i], 3'h0});
      chk(32'(int_freq_select), 32'(codes[i]));
    end
    axw(ADDR_OSC_CTRL, 32'hf7, r);
    axr(ADDR_OSC_CTRL, d, r);
    chk(d, 32'hf3);
    chk(32'({pll_on, hf_pll_boost}), 32'h3);
    axw(8'h08, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(8'h08, d, r);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    axw(ADDR_OSC_CTRL, 32'h58, r);
    @(posedge aclk);
    chk(32'(pll_on), 32'h0);
    chk(32'(startup_done), 32'h0);
    wfor(2, 30, n0);
    wfor(3, 400, n0);
    axw(ADDR_FAIL_STAT, 32'h2, r);
    run <= 1'b0;
    wfor(0, 200, n0);
    repeat (3) @(posedge aclk);
    chk(32'({failsafe_active, osc_fail_irq}), 32'h3);
    wfor(2, 40, n0);
    chk(32'(int_freq_select), 32'hb);
    axw(ADDR_FAIL_STAT, 32'h3, r);
    chk(32'(osc_fail_flag), 32'h1);
    run <= 1'b1;
    repeat (100) @(posedge aclk);
    chk(32'(sys_src), 32'(SRC_INT));
    axw(ADDR_OSC_CTRL, 32'h5a, r);
    repeat (2) @(posedge aclk);
    chk(32'(failsafe_active), 32'h0);
    axw(ADDR_OSC_CTRL, 32'h58, r);
    wfor(3, 400, n0);
    axw(ADDR_FAIL_STAT, 32'h3, r);
    repeat (2) @(posedge aclk);
    chk(32'({osc_fail_flag, osc_fail_irq}), 32'h0);
    run <= 1'b0;
    wfor(0, 200, n0);
    pulse_sleep(1'b0);
    repeat (8) @(posedge aclk);
    chk(32'({failsafe_active, sys_src}), 32'(SRC_OFF));
    axw(ADDR_FAIL_STAT, 32'h3, r);
    pulse_sleep(1'b1);
    repeat (200) @(posedge aclk);
    chk(32'({osc_fail_flag, startup_done}), 32'h0);
    run <= 1'b1;
    wfor(1, 400, n0);
    cfg <= '{two_speed: 1'b0, monitor_en: 1'b0, pll_en: 1'b1, osc_mode: MODE_RC};
    rst();
    wfor(1, 4, n0);
    chk(32'({pll_on, hf_pll_boost}), 32'h2);
    run <= 1'b0;
    repeat (200) @(posedge aclk);
    chk(32'(osc_fail_flag), 32'h0);
    results();
  end
endmodule
`default_nettype wire
